// [hw/cocc_fifo.sv]
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module cocc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = count_ff != (AW+1)'(DEPTH);
    assign out_valid = count_ff != '0;
    assign out_data  = mem[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// [hw/cocc_link_if.sv]
// Frame-level link between master end and slave end
`timescale 1ns/1ps
interface cocc_link_if;
    // Master to slave frames
    logic                       m2s_valid;
    logic                       m2s_ready;
    logic [cocc_pkg::ID_W-1:0]  m2s_id;
    logic                       m2s_ext;
    logic [3:0]                 m2s_len;
    logic [cocc_pkg::DATA_W-1:0] m2s_data;
    // Slave to master frames
    logic                       s2m_valid;
    logic                       s2m_ready;
    logic [cocc_pkg::ID_W-1:0]  s2m_id;
    logic [3:0]                 s2m_len;
    logic [cocc_pkg::DATA_W-1:0] s2m_data;

    modport master (output m2s_valid, m2s_id, m2s_ext, m2s_len, m2s_data,
                    input m2s_ready,
                    input s2m_valid, s2m_id, s2m_len, s2m_data, output s2m_ready);
    modport slave  (input m2s_valid, m2s_id, m2s_ext, m2s_len, m2s_data,
                    output m2s_ready,
                    output s2m_valid, s2m_id, s2m_len, s2m_data, input s2m_ready);
endinterface

// [hw/cocc_master.sv]
// CANopen master end: sends NMT, SYNC, RPDO and SDO requests, returns slave frames
`timescale 1ns/1ps
module cocc_master (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Link
    cocc_link_if.master                       link,
    // Command from user
    input  wire logic                         cmd_valid,
    output logic                              cmd_ready,
    input  wire logic [cocc_pkg::ID_W-1:0]    cmd_id,
    input  wire logic [3:0]                   cmd_len,
    input  wire logic [cocc_pkg::DATA_W-1:0]  cmd_data,
    // Frames from slaves
    output logic                              rsp_valid,
    output logic [cocc_pkg::ID_W-1:0]         rsp_id,
    output logic [3:0]                        rsp_len,
    output logic [cocc_pkg::DATA_W-1:0]       rsp_data
);
    // Held until the slave takes it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.m2s_valid <= 1'b0;
            link.m2s_id    <= '0;
            link.m2s_ext   <= 1'b0;
            link.m2s_len   <= '0;
            link.m2s_data  <= '0;
        end else if (cmd_valid && cmd_ready) begin
            link.m2s_valid <= 1'b1;
            link.m2s_id    <= cmd_id;
            link.m2s_len   <= cmd_len;
            link.m2s_data  <= cmd_data;
        end else if (link.m2s_ready) begin
            link.m2s_valid <= 1'b0;
        end
    end
    assign cmd_ready = !link.m2s_valid || link.m2s_ready;

    assign link.s2m_ready = 1'b1;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_id    <= '0;
            rsp_len   <= '0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= link.s2m_valid;
            rsp_id    <= link.s2m_id;
            rsp_len   <= link.s2m_len;
            rsp_data  <= link.s2m_data;
        end
    end
endmodule

// [hw/cocc_pkg.sv]
// Shared constants and types for the CANopen identifier classifier
package cocc_pkg;
    localparam int ID_W   = 11;
    localparam int FC_MSB = 10;
    localparam int FC_LSB = 7;
    localparam int NODE_W = 7;
    localparam int DATA_W = 64;
    localparam int FIFO_DEPTH = 16;
    // Frame word in the FIFO: identifier, length, payload
    localparam int FRAME_W = ID_W + 4 + DATA_W;
    localparam logic [3:0]  FC_NMT  = 4'h0;
    localparam logic [10:0] ID_SYNC = 11'h080;
    localparam logic [10:0] ID_EMCY = 11'h081;
    localparam logic [10:0] ID_TPDO1 = 11'h181;
    localparam logic [10:0] ID_RPDO1 = 11'h201;
    localparam logic [10:0] ID_TPDO2 = 11'h281;
    localparam logic [10:0] ID_RPDO2 = 11'h301;
    localparam logic [10:0] ID_TPDO3 = 11'h381;
    localparam logic [10:0] ID_RPDO3 = 11'h401;
    localparam logic [10:0] ID_TPDO4 = 11'h481;
    localparam logic [10:0] ID_RPDO4 = 11'h501;
    localparam logic [10:0] ID_SDO_TX = 11'h581;
    localparam logic [10:0] ID_SDO_RX = 11'h601;
    localparam logic [10:0] ID_GUARD = 11'h701;
    localparam logic [6:0]  NODE_BASE_MASK = 7'h7F;
    // Node-control command specifiers in NMT byte 0
    localparam logic [7:0] NMT_START = 8'h01;
    localparam logic [7:0] NMT_STOP  = 8'h02;
    localparam logic [7:0] NMT_PREOP = 8'h80;
    localparam logic [7:0] NMT_RESET_NODE = 8'h81;
    localparam logic [7:0] NMT_RESET_COMM = 8'h82;
    // Heartbeat state codes
    localparam logic [7:0] HB_BOOT  = 8'h00;
    localparam logic [7:0] HB_STOP  = 8'h04;
    localparam logic [7:0] HB_OPER  = 8'h05;
    localparam logic [7:0] HB_PREOP = 8'h7F;
    localparam int HB_PERIOD_US = 1000;
    localparam int CLK_MHZ = 40;
    localparam int HB_CYCLES = HB_PERIOD_US * CLK_MHZ;

    typedef enum logic [1:0] {
        COCC_BOOT  = 2'b00,
        COCC_PREOP = 2'b01,
        COCC_OPER  = 2'b10,
        COCC_STOP  = 2'b11
    } cocc_nmt_t;

    typedef enum logic [3:0] {
        COCC_K_NONE = 4'h0,
        COCC_K_NMT  = 4'h1,
        COCC_K_SYNC = 4'h2,
        COCC_K_RPDO1 = 4'h3,
        COCC_K_RPDO2 = 4'h4,
        COCC_K_RPDO3 = 4'h5,
        COCC_K_RPDO4 = 4'h6,
        COCC_K_SDO  = 4'h7
    } cocc_kind_t;
endpackage

// [hw/cocc_slave.sv]
// CANopen slave end: identifier classifier, NMT state and producers
// Operation
// - Identifiers are eleven bits in ID field
// - Bits 10..7 function, 6..0 node address
// - NMT code 0000, SYNC 80h, no address
// - Consume SYNC only; may trigger PDO transmission
// - Produce EMCY at 81h plus node on error
// - TPDO1 181h, RPDO1 201h plus node
// - TPDO2 281h, RPDO2 301h plus node
// - TPDO3 381h, RPDO3 401h plus node
// - TPDO4 481h, RPDO4 501h plus node
// - SDO response 581h, request 601h plus node
// - SDO server only, never issues requests
// - Heartbeat at 701h plus node address
// - Send heartbeat periodically to the master
// - Execute received NMT commands, change state
// - Compare against programmable identifiers, not constants; NMT is still matched on constant FC_NMT
// - PDOs carry no index, mapped beforehand
// - SDO data carries explicit object index
// - Node address unique, range 1 to 127
// - Multi-byte values sent low byte first
// - Accept only standard frames, drop extended
`timescale 1ns/1ps
module cocc_slave (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Link
    cocc_link_if.slave                        link,
    // Configuration
    input  wire logic [cocc_pkg::NODE_W-1:0]  node_id,
    input  wire logic                         cfg_we,
    input  wire logic [3:0]                   cfg_sel,
    input  wire logic [cocc_pkg::ID_W-1:0]    cfg_id,
    // Received frame to user
    output logic                              rx_valid,
    output logic [3:0]                        rx_kind,
    output logic [3:0]                        rx_len,
    output logic [cocc_pkg::DATA_W-1:0]       rx_data,
    output logic [15:0]                       rx_sdo_index,
    // Transmit requests from user
    input  wire logic                         tx_req,
    input  wire logic [2:0]                   tx_sel,
    input  wire logic [3:0]                   tx_len,
    input  wire logic [cocc_pkg::DATA_W-1:0]  tx_data,
    output logic                              tx_busy,
    input  wire logic                         err_event,
    input  wire logic [15:0]                  err_code,
    // State
    output logic [1:0]                        nmt_state,
    output logic                              sync_pulse
);
    // Programmable identifier table, index by cfg_sel
    localparam int NCFG = 12;
    logic [cocc_pkg::ID_W-1:0] cob_ff [NCFG];

    cocc_pkg::cocc_nmt_t state_ff;
    logic [cocc_pkg::NODE_W-1:0] node_ff;
    logic                        node_ok;
    logic [cocc_pkg::ID_W-1:0]   full_id [NCFG];
    cocc_pkg::cocc_kind_t        kind;
    logic [31:0]                 hb_cnt_ff;
    logic                        hb_due_ff;
    logic                        emcy_due_ff;
    logic [15:0]                 emcy_code_ff;
    logic                        hb_send;
    logic                        emcy_send;
    logic                        user_send;

    // Reconfigurable identifiers; the node part is added unless the entry is SYNC
    // Address latched at boot so a live change cannot split a frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCFG; i++) begin
                cob_ff[i] <= '0;
            end
            node_ff <= '0;
        end else if (state_ff == cocc_pkg::COCC_BOOT) begin
            cob_ff  <= '{cocc_pkg::ID_SYNC, cocc_pkg::ID_EMCY,
                         cocc_pkg::ID_TPDO1, cocc_pkg::ID_RPDO1,
                         cocc_pkg::ID_TPDO2, cocc_pkg::ID_RPDO2,
                         cocc_pkg::ID_TPDO3, cocc_pkg::ID_RPDO3,
                         cocc_pkg::ID_TPDO4, cocc_pkg::ID_RPDO4,
                         cocc_pkg::ID_SDO_TX, cocc_pkg::ID_SDO_RX};
            node_ff <= node_id;
        end else if (cfg_we && state_ff != cocc_pkg::COCC_OPER &&
                     int'(cfg_sel) < NCFG) begin
            cob_ff[cfg_sel] <= cfg_id;
        end
    end
    assign node_ok = node_ff != '0;

    always_comb begin
        for (int i = 0; i < NCFG; i++) begin
            full_id[i] = (i == 0) ? cob_ff[i] : cob_ff[i] + {4'h0, node_ff} - 11'h001;
        end
    end

    // Classification of the head frame
    always_comb begin
        kind = cocc_pkg::COCC_K_NONE;
        if (link.m2s_ext) begin
            kind = cocc_pkg::COCC_K_NONE;
        end else if (link.m2s_id[cocc_pkg::FC_MSB:cocc_pkg::FC_LSB] == cocc_pkg::FC_NMT &&
                     link.m2s_id[cocc_pkg::NODE_W-1:0] == '0) begin
            kind = cocc_pkg::COCC_K_NMT;
        end else if (link.m2s_id == full_id[0]) begin
            kind = cocc_pkg::COCC_K_SYNC;
        end else if (!node_ok) begin
            kind = cocc_pkg::COCC_K_NONE;
        end else if (link.m2s_id == full_id[3]) begin
            kind = cocc_pkg::COCC_K_RPDO1;
        end else if (link.m2s_id == full_id[5]) begin
            kind = cocc_pkg::COCC_K_RPDO2;
        end else if (link.m2s_id == full_id[7]) begin
            kind = cocc_pkg::COCC_K_RPDO3;
        end else if (link.m2s_id == full_id[9]) begin
            kind = cocc_pkg::COCC_K_RPDO4;
        end else if (link.m2s_id == full_id[11]) begin
            kind = cocc_pkg::COCC_K_SDO;
        end
        // EMCY and TPDO identifiers are never consumed; unmatched frames drop here
    end

    assign link.m2s_ready = 1'b1;

    // Delivery to user; PDOs only when operational
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_valid     <= 1'b0;
            rx_kind      <= '0;
            rx_len       <= '0;
            rx_data      <= '0;
            rx_sdo_index <= '0;
            sync_pulse   <= 1'b0;
            nmt_state    <= cocc_pkg::COCC_BOOT;
            tx_busy      <= 1'b0;
        end else begin
            rx_valid   <= 1'b0;
            sync_pulse <= 1'b0;
            nmt_state  <= state_ff;
            tx_busy    <= tx_req && !user_send;
            if (link.m2s_valid && kind != cocc_pkg::COCC_K_NONE &&
                state_ff != cocc_pkg::COCC_BOOT &&
                (state_ff == cocc_pkg::COCC_OPER || kind == cocc_pkg::COCC_K_NMT ||
                 (state_ff == cocc_pkg::COCC_PREOP && kind != cocc_pkg::COCC_K_RPDO1 &&
                  kind != cocc_pkg::COCC_K_RPDO2 && kind != cocc_pkg::COCC_K_RPDO3 &&
                  kind != cocc_pkg::COCC_K_RPDO4))) begin
                rx_valid     <= 1'b1;
                rx_kind      <= kind;
                rx_len       <= link.m2s_len;
                rx_data      <= link.m2s_data;
                rx_sdo_index <= link.m2s_data[23:8];
                sync_pulse   <= kind == cocc_pkg::COCC_K_SYNC;
            end
        end
    end

    // NMT state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= cocc_pkg::COCC_BOOT;
        end else if (state_ff == cocc_pkg::COCC_BOOT) begin
            state_ff <= cocc_pkg::COCC_PREOP;
        end else if (link.m2s_valid && kind == cocc_pkg::COCC_K_NMT &&
                     (link.m2s_data[15:8] == 8'h00 ||
                      link.m2s_data[14:8] == node_ff)) begin
            case (link.m2s_data[7:0])
                cocc_pkg::NMT_START:      state_ff <= cocc_pkg::COCC_OPER;
                cocc_pkg::NMT_STOP:       state_ff <= cocc_pkg::COCC_STOP;
                cocc_pkg::NMT_PREOP:      state_ff <= cocc_pkg::COCC_PREOP;
                cocc_pkg::NMT_RESET_NODE: state_ff <= cocc_pkg::COCC_BOOT;
                cocc_pkg::NMT_RESET_COMM: state_ff <= cocc_pkg::COCC_BOOT;
                default:                  state_ff <= state_ff;
            endcase
        end
    end

    // Heartbeat timer counts 1..HB_CYCLES; a zero count only just after boot marks boot-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hb_cnt_ff <= '0;
            hb_due_ff <= 1'b0;
        end else if (state_ff == cocc_pkg::COCC_BOOT) begin
            hb_cnt_ff <= '0;
            hb_due_ff <= 1'b1;
        end else begin
            if (hb_cnt_ff == 32'(cocc_pkg::HB_CYCLES)) begin
                hb_cnt_ff <= 32'h0000_0001;
                hb_due_ff <= 1'b1;
            end else begin
                hb_cnt_ff <= hb_cnt_ff + 32'h0000_0001;
                if (hb_send) begin
                    hb_due_ff <= 1'b0;
                end
            end
        end
    end

    // Pending error; a new error wins over the clear of the old one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emcy_due_ff  <= 1'b0;
            emcy_code_ff <= '0;
        end else if (err_event) begin
            emcy_due_ff  <= 1'b1;
            emcy_code_ff <= err_code;
        end else if (emcy_send) begin
            emcy_due_ff <= 1'b0;
        end
    end

    // Transmit arbiter into the outgoing FIFO
    logic                         f_in_valid;
    logic                         f_in_ready;
    logic [cocc_pkg::FRAME_W-1:0] f_in_data;
    logic [cocc_pkg::FRAME_W-1:0] f_out_data;
    logic [7:0]                   hb_code;
    logic [cocc_pkg::ID_W-1:0]    user_id;

    always_comb begin
        case (state_ff)
            cocc_pkg::COCC_OPER: hb_code = cocc_pkg::HB_OPER;
            cocc_pkg::COCC_STOP: hb_code = cocc_pkg::HB_STOP;
            cocc_pkg::COCC_PREOP: hb_code = hb_cnt_ff == '0 ? cocc_pkg::HB_BOOT
                                                             : cocc_pkg::HB_PREOP;
            default:             hb_code = cocc_pkg::HB_BOOT;
        endcase
        case (tx_sel)
            3'd1:    user_id = full_id[4];
            3'd2:    user_id = full_id[6];
            3'd3:    user_id = full_id[8];
            3'd4:    user_id = full_id[10];
            default: user_id = full_id[2];
        endcase
    end

    assign emcy_send = f_in_ready && emcy_due_ff && node_ok &&
                       state_ff != cocc_pkg::COCC_STOP && state_ff != cocc_pkg::COCC_BOOT;
    assign hb_send   = f_in_ready && hb_due_ff && !emcy_send && node_ok &&
                       state_ff != cocc_pkg::COCC_BOOT;
    assign user_send = f_in_ready && tx_req && !emcy_send && !hb_send && node_ok &&
                       (state_ff == cocc_pkg::COCC_OPER ||
                        (tx_sel == 3'd4 && state_ff == cocc_pkg::COCC_PREOP));
    assign f_in_valid = emcy_send || hb_send || user_send;

    always_comb begin
        if (emcy_send) begin
            f_in_data = {full_id[1], 4'd8, 48'h0, emcy_code_ff};
        end else if (hb_send) begin
            f_in_data = {cocc_pkg::ID_GUARD + {4'h0, node_ff} - 11'h001, 4'd1, 56'h0, hb_code};
        end else begin
            f_in_data = {user_id, tx_len, tx_data};
        end
    end

    cocc_fifo #(
        .WIDTH (cocc_pkg::FRAME_W),
        .DEPTH (cocc_pkg::FIFO_DEPTH)
    ) u_txq (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (link.s2m_valid),
        .out_ready (link.s2m_ready),
        .out_data  (f_out_data)
    );
    assign link.s2m_id   = f_out_data[cocc_pkg::FRAME_W-1 -: cocc_pkg::ID_W];
    assign link.s2m_len  = f_out_data[cocc_pkg::DATA_W +: 4];
    assign link.s2m_data = f_out_data[cocc_pkg::DATA_W-1:0];
endmodule

// [verif/canopen_cob_id_classifier_bench.sv]
// Bench joining master and slave ends through the frame link
`timescale 1ns/1ps
module canopen_cob_id_classifier_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  node_id = 7'h05;
    logic        cfg_we = 1'b0;
    logic [3:0]  cfg_sel = 4'h0;
    logic [10:0] cfg_id = 11'h000;
    logic        rx_valid, tx_busy, sync_pulse, cmd_ready, rsp_valid;
    logic [3:0]  rx_kind, rx_len, rsp_len;
    logic [63:0] rx_data, rsp_data;
    logic [15:0] rx_sdo_index;
    logic [1:0]  nmt_state;
    logic [10:0] rsp_id;
    logic        tx_req = 1'b0;
    logic [2:0]  tx_sel = 3'h0;
    logic [63:0] tx_data = 64'h0;
    logic        err_event = 1'b0;
    logic [15:0] err_code = 16'h0;
    logic        cmd_valid = 1'b0;
    logic [10:0] cmd_id = 11'h000;
    logic [3:0]  cmd_len = 4'h0;
    logic [63:0] cmd_data = 64'h0;
    int          failures = 0;
    int          comparisons = 0;
    logic [10:0] ids [5] = '{11'h185, 11'h285, 11'h385, 11'h485, 11'h585};

    always #12.5 clk = ~clk;

    cocc_link_if u_cocc_link_if ();
    cocc_slave u_cocc_slave (.clk(clk), .rst(rst), .link(u_cocc_link_if.slave),
        .node_id(node_id), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_id(cfg_id),
        .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_len(rx_len), .rx_data(rx_data),
        .rx_sdo_index(rx_sdo_index), .tx_req(tx_req), .tx_sel(tx_sel), .tx_len(4'h8),
        .tx_data(tx_data), .tx_busy(tx_busy), .err_event(err_event), .err_code(err_code),
        .nmt_state(nmt_state), .sync_pulse(sync_pulse));
    cocc_master u_cocc_master (.clk(clk), .rst(rst), .link(u_cocc_link_if.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_len(cmd_len),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_id(rsp_id), .rsp_len(rsp_len),
        .rsp_data(rsp_data));
    cocc_link_sva #(.NODE(7'h05)) u_cocc_link_sva (.clk(clk), .rst(rst),
        .m2s_valid(u_cocc_link_if.m2s_valid), .m2s_ext(u_cocc_link_if.m2s_ext),
        .s2m_valid(u_cocc_link_if.s2m_valid), .s2m_ready(u_cocc_link_if.s2m_ready),
        .s2m_id(u_cocc_link_if.s2m_id), .s2m_len(u_cocc_link_if.s2m_len),
        .s2m_data(u_cocc_link_if.s2m_data));

    task automatic final_report;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic hang;
        failures++;
        final_report;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Master command handshake, held until cmd_ready is seen
    task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_id <= id;
        cmd_len <= len;
        cmd_data <= d;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        if (cmd_ready !== 1'b1)
            hang;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    // Expect a delivered frame, or with on=0 that nothing is delivered
    task automatic rx(input bit on, input logic [3:0] kind, input logic [63:0] d);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 30);
        if (!on)
            chk(rx_valid, 1'b0);
        else if (rx_valid !== 1'b1)
            hang;
        else begin
            chk(rx_kind, kind);
            chk(rx_data, d);
        end
    endtask

    task automatic rsp(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d,
                       input logic [63:0] m, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < lim);
        if (rsp_valid !== 1'b1)
            hang;
        chk(rsp_id, id);
        chk(rsp_len, len);
        chk(rsp_data & m, d);
    endtask

    task automatic nmt(input logic [7:0] cmd, input logic [1:0] st);
        send(11'h000, 4'h2, {48'h0, 8'h05, cmd});
        rx(1'b1, cocc_pkg::COCC_K_NMT, {48'h0, 8'h05, cmd});
        repeat (3) @(negedge clk);
        chk(nmt_state, st);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rsp(11'h705, 4'h1, 64'h0, 64'hFF, 50);
        chk(nmt_state, cocc_pkg::COCC_PREOP);
        send(11'h205, 4'h8, 64'h1); rx(1'b0, 4'h0, 64'h0);
        send(11'h606, 4'h8, 64'h1); rx(1'b0, 4'h0, 64'h0);
        nmt(cocc_pkg::NMT_START, cocc_pkg::COCC_OPER);
        $display("test nmt_start done");
        for (int i = 0; i < 4; i++) begin
            send(11'h205 + 11'(i) * 11'h100, 4'h8, 64'h1122_3344_5566_7700 + 64'(i));
            rx(1'b1, 4'(3 + i), 64'h1122_3344_5566_7700 + 64'(i));
        end
        send(11'h605, 4'h8, 64'h0012_3440); rx(1'b1, cocc_pkg::COCC_K_SDO, 64'h0012_3440);
        chk(rx_sdo_index, 16'h1234);
        send(11'h080, 4'h0, 64'h0); rx(1'b1, cocc_pkg::COCC_K_SYNC, 64'h0);
        chk(sync_pulse, 1'b1);
        send(11'h085, 4'h8, 64'h1); rx(1'b0, 4'h0, 64'h0);
        $display("test receive done");
        for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            tx_req <= 1'b1;
            tx_sel <= 3'(s);
            tx_data <= 64'hA5A5_0000_0000_0000 + 64'(s);
            @(posedge clk);
            tx_req <= 1'b0;
            rsp(ids[s], 4'h8, 64'hA5A5_0000_0000_0000 + 64'(s), '1, 50);
        end
        // Back-to-back requests leave the transmit queue one per cycle, in order
        for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            tx_req <= j < 4;
            tx_sel <= 3'(j);
            tx_data <= 64'(j);
            @(negedge clk);
            if (j > 1) begin
                chk(rsp_valid, 1'b1);
                chk(rsp_id, ids[j - 2]);
                chk(rsp_data, 64'(j - 2));
            end
        end
        $display("test tx_queue done");
        @(posedge clk);
        err_event <= 1'b1;
        err_code <= 16'hABCD;
        @(posedge clk);
        err_event <= 1'b0;
        rsp(11'h085, 4'h8, 64'hABCD, 64'hFFFF, 50);
        $display("test transmit done");
        nmt(cocc_pkg::NMT_PREOP, cocc_pkg::COCC_PREOP);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_sel <= 3'h0;
        @(posedge clk);
        tx_req <= 1'b0;
        @(negedge clk);
        chk(tx_busy, 1'b1);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_sel <= 4'hB;
        cfg_id <= 11'h641;
        @(posedge clk);
        cfg_we <= 1'b0;
        send(11'h645, 4'h3, 64'h0012_3440); rx(1'b1, cocc_pkg::COCC_K_SDO, 64'h0012_3440);
        send(11'h605, 4'h3, 64'h1); rx(1'b0, 4'h0, 64'h0);
        nmt(cocc_pkg::NMT_STOP, cocc_pkg::COCC_STOP);
        send(11'h205, 4'h8, 64'h1); rx(1'b0, 4'h0, 64'h0);
        rsp(11'h705, 4'h1, 64'h04, 64'hFF, 45000);
        $display("test config_and_heartbeat done");
        send(11'h000, 4'h2, {48'h0, 8'h05, cocc_pkg::NMT_RESET_NODE});
        rx(1'b1, cocc_pkg::COCC_K_NMT, {48'h0, 8'h05, cocc_pkg::NMT_RESET_NODE});
        rsp(11'h705, 4'h1, 64'h0, 64'hFF, 60);
        chk(nmt_state, cocc_pkg::COCC_PREOP);
        $display("test reset_node done");
        final_report;
    end
endmodule

// [verif/cocc_link_sva.sv]
// Link checker for frames crossing between master and slave ends
`timescale 1ns/1ps
module cocc_link_sva #(
    parameter logic [6:0] NODE = 7'h05
) (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // Master to slave
    input wire logic                          m2s_valid,
    input wire logic                          m2s_ext,
    // Slave to master
    input wire logic                          s2m_valid,
    input wire logic                          s2m_ready,
    input wire logic [cocc_pkg::ID_W-1:0]     s2m_id,
    input wire logic [3:0]                    s2m_len,
    input wire logic [cocc_pkg::DATA_W-1:0]   s2m_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_std_id_only: assert property (m2s_valid |-> !m2s_ext)
        else $error("extended frame sent");
    a_ready_held: assert property (s2m_ready)
        else $error("slave frames not accepted");
    a_tx_func_code: assert property (s2m_valid |-> s2m_id[10:7] inside
        {4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hE})
        else $error("slave sent a consumed object type");
    a_node_field: assert property (s2m_valid |-> s2m_id[6:0] == NODE)
        else $error("slave frame carries wrong node");
    a_hb_len: assert property (s2m_valid && s2m_id[10:7] == 4'hE |-> s2m_len == 4'h1)
        else $error("heartbeat length wrong");
    a_emcy_len: assert property (s2m_valid && s2m_id[10:7] == 4'h1 |-> s2m_len == 4'h8)
        else $error("emergency length wrong");
    a_hb_code: assert property (s2m_valid && s2m_id[10:7] == 4'hE
        |-> s2m_data[7:0] inside {8'h00, 8'h04, 8'h05, 8'h7F})
        else $error("heartbeat state code wrong");
    a_hb_spacing: assert property (s2m_valid && s2m_id[10:7] == 4'hE
        |=> !(s2m_valid && s2m_id[10:7] == 4'hE) [*8])
        else $error("heartbeat repeated too soon");
endmodule
